// ===== rtl/instr_exec_pkg.sv
// Purpose: shared constants and types for the return/rotate execution slice
// Assumes: 16-bit instruction words, 8-bit data path, 21-bit program counter
// Notes: register offsets are byte addresses on the plain register port
package instr_exec_pkg;
  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int ADDR_W = 12;
  localparam int STACK_DEPTH = 31;
  localparam int PTR_W = 5;

  // register offsets
  localparam logic [11:0] OFF_INSTR = 12'h000;
  localparam logic [11:0] OFF_CTRL = 12'h004;
  localparam logic [11:0] OFF_ACC = 12'h008;
  localparam logic [11:0] OFF_FLAGS = 12'h00C;
  localparam logic [11:0] OFF_BANK = 12'h010;
  localparam logic [11:0] OFF_ACC_SHADOW = 12'h014;
  localparam logic [11:0] OFF_FLAGS_SHADOW = 12'h018;
  localparam logic [11:0] OFF_BANK_SHADOW = 12'h01C;
  localparam logic [11:0] OFF_PC = 12'h020;
  localparam logic [11:0] OFF_STACK_HEAD = 12'h024;
  localparam logic [11:0] OFF_STACK_LEVEL = 12'h028;
  localparam logic [11:0] OFF_IRQ_EN = 12'h02C;
  localparam logic [11:0] OFF_PC_LATCH_HIGH = 12'h030;
  localparam logic [11:0] OFF_PC_LATCH_UPPER = 12'h034;
  localparam logic [11:0] OFF_FILE_BASE = 12'h400;

  // field positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 4;
  localparam int IRQ_EN_HIGH = 0;
  localparam int IRQ_EN_LOW = 1;
  localparam int CTRL_BUSY = 0;
  localparam int CTRL_LEVEL = 1;

  // opcode patterns
  localparam logic [15:0] EXIT_MASK = 16'hFFFE;
  localparam logic [15:0] IRQ_EXIT_PAT = 16'h0010;
  localparam logic [15:0] SUB_EXIT_PAT = 16'h0012;
  localparam logic [7:0] LIT_EXIT_PAT = 8'h0C;
  localparam logic [5:0] ROTATE_PAT = 6'h0D;

  // reset values and counts
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
  localparam logic [1:0] LAST_PHASE = 2'h3;
  localparam logic [1:0] READ_PHASE = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CYC1 = 3'b010,
    ST_CYC2 = 3'b100
  } exec_state_e;
endpackage : instr_exec_pkg

// ===== rtl/return_rotate_instr_exec.sv
// Purpose: executes the return family and rotate-left-through-carry
// Assumes: register port strobes are one cycle long, never together
// Notes: one clock per phase, four phases per instruction cycle;
//   all register writes, the instruction included, are ignored while busy
`timescale 1ns/10ps
module return_rotate_instr_exec
  import instr_exec_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  output logic busy_out,
  output logic [PC_W-1:0] pc_out
);
  // opcode decoders, shared by the sequencer, datapath and checks
  function automatic logic is_irq_exit(input logic [15:0] i);
    return (i & EXIT_MASK) == IRQ_EXIT_PAT;
  endfunction : is_irq_exit

  function automatic logic is_sub_exit(input logic [15:0] i);
    return (i & EXIT_MASK) == SUB_EXIT_PAT;
  endfunction : is_sub_exit

  function automatic logic is_lit_exit(input logic [15:0] i);
    return i[15:8] == LIT_EXIT_PAT;
  endfunction : is_lit_exit

  function automatic logic is_rotate(input logic [15:0] i);
    return i[15:10] == ROTATE_PAT;
  endfunction : is_rotate

  function automatic logic is_return(input logic [15:0] i);
    return is_irq_exit(i) || is_sub_exit(i) || is_lit_exit(i);
  endfunction : is_return

  // returns {carry out, result}
  function automatic logic [8:0] rotate_carry(input logic [7:0] v,
                                              input logic c);
    return {v[7], v[6:0], c};
  endfunction : rotate_carry

  stack_if stk ();
  exec_state_e state_reg;
  logic [1:0] phase_reg;
  logic busy_reg;
  logic [15:0] instr_reg;
  logic [7:0] acc_reg, flags_reg, acc_shadow_reg, flags_shadow_reg;
  logic [BANK_W-1:0] bank_reg, bank_shadow_reg;
  logic [PC_W-1:0] pc_reg;
  logic [1:0] irq_en_reg;
  logic level_sel_reg;
  logic [7:0] pc_latch_high_reg;
  logic [4:0] pc_latch_upper_reg;
  logic [7:0] lit_reg, opnd_reg;
  logic [7:0] file_mem [0:255];
  logic issue, bus_wr, exec_q2, exec_q4, restore, file_hit;
  logic [8:0] rot;
  logic [7:0] file_idx;
  logic [31:0] rd_mux;

  assign issue = wr_in && addr_in == OFF_INSTR && state_reg == ST_IDLE;
  assign bus_wr = wr_in && state_reg == ST_IDLE;
  assign exec_q2 = state_reg == ST_CYC1 && phase_reg == READ_PHASE;
  assign exec_q4 = state_reg == ST_CYC1 && phase_reg == LAST_PHASE;
  // shadow restore only for the two exits that carry the s bit
  assign restore = (is_irq_exit(instr_reg) || is_sub_exit(instr_reg))
                   && instr_reg[0];
  assign rot = rotate_carry(opnd_reg, flags_reg[FLAG_C]);
  assign file_hit = addr_in[11:10] == OFF_FILE_BASE[11:10];
  assign file_idx = addr_in[9:2];

  // phase sequencer: returns add an idle second cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      phase_reg <= 2'h0;
      busy_reg <= 1'b0;
    end else if (issue) begin
      state_reg <= ST_CYC1;
      phase_reg <= 2'h0;
      busy_reg <= 1'b1;
    end else begin
      case (state_reg)
        ST_CYC1: begin
          phase_reg <= phase_reg + 1'b1;
          if (phase_reg == LAST_PHASE) begin
            if (is_return(instr_reg)) begin
              state_reg <= ST_CYC2;
            end else begin
              state_reg <= ST_IDLE;
              busy_reg <= 1'b0;
            end
          end
        end
        ST_CYC2: begin
          phase_reg <= phase_reg + 1'b1; // no operation
          if (phase_reg == LAST_PHASE) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          phase_reg <= 2'h0;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // instruction latch and phase-two operand fetch
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      instr_reg <= 16'h0000;
      lit_reg <= DATA_RST;
      opnd_reg <= DATA_RST;
    end else if (issue) begin
      instr_reg <= wr_data_in[15:0];
    end else if (exec_q2) begin
      lit_reg <= instr_reg[7:0]; // literal read in phase two
      opnd_reg <= file_mem[instr_reg[7:0]];
    end
  end

  // accumulator
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_reg <= DATA_RST;
    end else if (bus_wr && addr_in == OFF_ACC) begin
      acc_reg <= wr_data_in[7:0];
    end else if (exec_q4) begin
      if (is_lit_exit(instr_reg)) begin
        acc_reg <= lit_reg;
      end else if (restore) begin
        acc_reg <= acc_shadow_reg;
      end else if (is_rotate(instr_reg) && !instr_reg[9]) begin
        acc_reg <= rot[7:0];
      end
    end
  end

  // status flags: besides software writes, only rotate and a shadow restore change them
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flags_reg <= DATA_RST;
    end else if (bus_wr && addr_in == OFF_FLAGS) begin
      flags_reg <= wr_data_in[7:0];
    end else if (exec_q4) begin
      if (restore) begin
        flags_reg <= flags_shadow_reg;
      end else if (is_rotate(instr_reg)) begin
        flags_reg[FLAG_C] <= rot[8];
        flags_reg[FLAG_N] <= rot[7];
        flags_reg[FLAG_Z] <= rot[7:0] == 8'h00;
      end
    end
  end

  // bank pointer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bank_reg <= '0;
    end else if (bus_wr && addr_in == OFF_BANK) begin
      bank_reg <= wr_data_in[BANK_W-1:0];
    end else if (exec_q4 && restore) begin
      bank_reg <= bank_shadow_reg;
    end
  end

  // shadows are filled by the interrupt entry logic, here by software
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_shadow_reg <= DATA_RST;
      flags_shadow_reg <= DATA_RST;
      bank_shadow_reg <= '0;
    end else if (bus_wr) begin
      if (addr_in == OFF_ACC_SHADOW) begin
        acc_shadow_reg <= wr_data_in[7:0];
      end else if (addr_in == OFF_FLAGS_SHADOW) begin
        flags_shadow_reg <= wr_data_in[7:0];
      end else if (addr_in == OFF_BANK_SHADOW) begin
        bank_shadow_reg <= wr_data_in[BANK_W-1:0];
      end
    end
  end

  // program counter takes the popped top; latches are never written here
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_reg <= '0;
    end else if (bus_wr && addr_in == OFF_PC) begin
      pc_reg <= wr_data_in[PC_W-1:0];
    end else if (exec_q4 && is_return(instr_reg)) begin
      pc_reg <= stk.head;
    end
  end

  // counter latches: software only, so returns leave them alone
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_latch_high_reg <= DATA_RST;
      pc_latch_upper_reg <= 5'h0;
    end else if (bus_wr && addr_in == OFF_PC_LATCH_HIGH) begin
      pc_latch_high_reg <= wr_data_in[7:0];
    end else if (bus_wr && addr_in == OFF_PC_LATCH_UPPER) begin
      pc_latch_upper_reg <= wr_data_in[4:0];
    end
  end

  // global enables; level select picks which one the exit sets
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_en_reg <= IRQ_EN_RST;
      level_sel_reg <= 1'b1;
    end else if (bus_wr && addr_in == OFF_IRQ_EN) begin
      irq_en_reg <= wr_data_in[1:0];
    end else if (bus_wr && addr_in == OFF_CTRL) begin
      level_sel_reg <= wr_data_in[CTRL_LEVEL];
    end else if (exec_q4 && is_irq_exit(instr_reg)) begin
      if (level_sel_reg) begin
        irq_en_reg[IRQ_EN_HIGH] <= 1'b1;
      end else begin
        irq_en_reg[IRQ_EN_LOW] <= 1'b1;
      end
    end
  end

  // file registers: software window and rotate write-back
  always_ff @(posedge clk_in) begin
    if (bus_wr && file_hit) begin
      file_mem[file_idx] <= wr_data_in[7:0];
    end else if (exec_q4 && is_rotate(instr_reg) && instr_reg[9]) begin
      file_mem[instr_reg[7:0]] <= rot[7:0];
    end
  end

  // return stack: software pushes, returns pop in phase four
  assign stk.push = bus_wr && addr_in == OFF_STACK_HEAD;
  assign stk.push_data = wr_data_in[PC_W-1:0];
  assign stk.pop = exec_q4 && is_return(instr_reg);

  return_stack #(.DEPTH(STACK_DEPTH)) u_stack (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .port_if(stk.stack)
  );

  // read decode; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_in == OFF_INSTR) begin
      rd_mux = {16'h0000, instr_reg};
    end else if (addr_in == OFF_CTRL) begin
      rd_mux = {30'h0, level_sel_reg, busy_reg};
    end else if (addr_in == OFF_ACC) begin
      rd_mux = {24'h00_0000, acc_reg};
    end else if (addr_in == OFF_FLAGS) begin
      rd_mux = {24'h00_0000, flags_reg};
    end else if (addr_in == OFF_BANK) begin
      rd_mux = {28'h000_0000, bank_reg};
    end else if (addr_in == OFF_ACC_SHADOW) begin
      rd_mux = {24'h00_0000, acc_shadow_reg};
    end else if (addr_in == OFF_FLAGS_SHADOW) begin
      rd_mux = {24'h00_0000, flags_shadow_reg};
    end else if (addr_in == OFF_BANK_SHADOW) begin
      rd_mux = {28'h000_0000, bank_shadow_reg};
    end else if (addr_in == OFF_PC) begin
      rd_mux = {11'h0, pc_reg};
    end else if (addr_in == OFF_STACK_HEAD) begin
      rd_mux = {11'h0, stk.head};
    end else if (addr_in == OFF_STACK_LEVEL) begin
      rd_mux = {27'h0, stk.level};
    end else if (addr_in == OFF_IRQ_EN) begin
      rd_mux = {30'h0, irq_en_reg};
    end else if (addr_in == OFF_PC_LATCH_HIGH) begin
      rd_mux = {24'h00_0000, pc_latch_high_reg};
    end else if (addr_in == OFF_PC_LATCH_UPPER) begin
      rd_mux = {27'h0, pc_latch_upper_reg};
    end else if (file_hit) begin
      rd_mux = {24'h00_0000, file_mem[file_idx]};
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= 32'h0000_0000;
    end else begin
      rd_data_out <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  assign busy_out = busy_reg;
  assign pc_out = pc_reg;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_ret_issue;
    issue && is_return(wr_data_in[15:0]);
  endsequence
  sequence s_two_cycles;
    busy_reg [*8] ##1 !busy_reg;
  endsequence

  chk_return_length: assert property (s_ret_issue |=> s_two_cycles)
    else $error("return did not take two instruction cycles");
  chk_rotate_length: assert property (
    issue && is_rotate(wr_data_in[15:0]) |=> busy_reg [*4] ##1 !busy_reg)
    else $error("rotate did not take one instruction cycle");
  chk_pop_to_pc: assert property (
    exec_q4 && is_return(instr_reg) |=> pc_reg == $past(stk.head))
    else $error("program counter not loaded from popped top");
  chk_stack_level: assert property (
    exec_q4 && is_return(instr_reg) && stk.level != '0
    |=> stk.level == $past(stk.level) - 1'b1)
    else $error("return stack did not drop one level");
  chk_exit_enable: assert property (
    exec_q4 && is_irq_exit(instr_reg) |=>
    irq_en_reg[level_sel_reg ? IRQ_EN_HIGH : IRQ_EN_LOW])
    else $error("interrupt exit did not set an enable");
  chk_sub_enables: assert property (
    exec_q4 && is_sub_exit(instr_reg) |=> $stable(irq_en_reg))
    else $error("subroutine exit changed interrupt enables");
  chk_shadow_restore: assert property (
    exec_q4 && restore |=> acc_reg == $past(acc_shadow_reg)
    && flags_reg == $past(flags_shadow_reg)
    && bank_reg == $past(bank_shadow_reg))
    else $error("shadow copies not restored");
  chk_literal_acc: assert property (
    issue && is_lit_exit(wr_data_in[15:0]) |-> ##5 acc_reg ==
    $past(wr_data_in[7:0], 5) && $stable(flags_reg))
    else $error("literal not in accumulator after phase four");
  chk_latch_kept: assert property (
    busy_reg |=> $stable(pc_latch_high_reg) && $stable(pc_latch_upper_reg))
    else $error("counter latch changed during execution");
  chk_rotate_acc: assert property (
    exec_q4 && is_rotate(instr_reg) && !instr_reg[9] |=>
    acc_reg == $past(rot[7:0]) && flags_reg[FLAG_C] == $past(opnd_reg[7]))
    else $error("rotate result or carry wrong");
endmodule : return_rotate_instr_exec

// ===== rtl/return_stack.sv
// Purpose: hardware return stack holding program counter values
// Assumes: push and pop never requested in the same cycle
// Notes: pop when empty and push when full are ignored
`timescale 1ns/10ps
module return_stack
  import instr_exec_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  stack_if.stack port_if
);
  logic [PC_W-1:0] mem [0:DEPTH-1];
  logic [PTR_W-1:0] level_reg;

  // level counts the entries; the top sits just below it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      level_reg <= '0;
    end else if (port_if.push && level_reg != PTR_W'(DEPTH)) begin
      level_reg <= level_reg + 1'b1;
    end else if (port_if.pop && level_reg != '0) begin
      level_reg <= level_reg - 1'b1; // previous entry becomes top
    end
  end

  // array kept without reset, only read below the level
  always_ff @(posedge clk_in) begin
    if (port_if.push && level_reg != PTR_W'(DEPTH)) begin
      mem[level_reg] <= port_if.push_data;
    end
  end

  // empty stack presents zero as the top value
  assign port_if.head = (level_reg == '0) ? '0 : mem[level_reg - 1'b1];
  assign port_if.level = level_reg;
endmodule : return_stack

// ===== rtl/stack_if.sv
// Purpose: carrier between the executer and its return stack
// Assumes: one push or pop per clock
// Notes: head is valid combinationally from the stack array
`timescale 1ns/10ps
interface stack_if;
  import instr_exec_pkg::*;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] head;
  logic [PTR_W-1:0] level;
  modport user (output push, output pop, output push_data,
                input head, input level);
  modport stack (input push, input pop, input push_data,
                 output head, output level);
endinterface : stack_if

// ===== test/tb_top.sv
// Purpose: self-checking bench for the return and rotate execution slice
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes: stack is loaded through the head register; three entries up front, then one before each later return
`timescale 1ns/10ps
module tb_top
  import instr_exec_pkg::*;
;
  logic clk_in;
  logic nrst_in;
  logic wr_in;
  logic rd_in;
  logic busy_out;
  logic [ADDR_W-1:0] addr_in;
  logic [31:0] wr_data_in;
  logic [31:0] rd_data_out;
  logic [PC_W-1:0] pc_out;
  logic [PC_W-1:0] pc0;
  logic [PC_W-1:0] pc_c4;
  logic [PC_W-1:0] pc_c5;
  int n_mismatch = 0;
  int comparisons = 0;
  int i;
  localparam logic [11:0] F20 = 12'h480;
  // rotate cases: operand, carry in, destination, result, flags after
  logic [7:0] rv [4] = '{8'h81, 8'h81, 8'h80, 8'h40};
  logic [7:0] cin [4] = '{8'h00, 8'h01, 8'h00, 8'h01};
  logic dsel [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  logic [7:0] res [4] = '{8'h02, 8'h03, 8'h00, 8'h81};
  logic [7:0] fl [4] = '{8'h01, 8'h01, 8'h05, 8'h10};

  return_rotate_instr_exec return_rotate_instr_exec_inst (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rd_data_out(rd_data_out),
    .busy_out(busy_out),
    .pc_out(pc_out)
  );

  // 40 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe edge
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                      input string name);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(name, rd_data_out, exp);
  endtask : rchk

  // issue one opcode and count busy cycles; pc snapshots in cycles 4 and 5
  task automatic exec(input logic [15:0] op, input int n_exp);
    int n;
    #1; // step off the edge the previous task ended on
    pc0 = pc_out;
    wr(OFF_INSTR, {16'h0000, op});
    n = 0;
    #1;
    while (busy_out === 1'b1 && n < 20) begin
      n++;
      if (n == 4) pc_c4 = pc_out;
      if (n == 5) pc_c5 = pc_out;
      @(posedge clk_in);
      #1;
    end
    chk("busy cycles", 32'(n), 32'(n_exp));
  endtask : exec

  // counter must hold through the fourth phase, then show the popped value
  task automatic ret_chk(input logic [15:0] op, input logic [PC_W-1:0] pcn);
    exec(op, 8);
    chk("pc in cycle 4", 32'(pc_c4), 32'(pc0));
    chk("pc in cycle 5", 32'(pc_c5), 32'(pcn));
    rchk(OFF_PC, 32'(pcn), "pc reg");
  endtask : ret_chk

  // watchdog: the sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    wrap_up();
  end

  // main sequence
  initial begin
    nrst_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 12'h000;
    wr_data_in = 32'h00000000;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    rchk(OFF_ACC, 32'h0, "acc reset");
    rchk(OFF_CTRL, 32'h2, "ctrl reset");
    rchk(OFF_IRQ_EN, 32'h0, "irq enable reset");
    rchk(OFF_STACK_LEVEL, 32'h0, "level reset");
    rchk(12'h0FC, 32'h0, "unmapped read");
    @(posedge clk_in);
    #1;
    chk("read data released", rd_data_out, 32'h0);
    // three return addresses, shadows and latches with distinct values
    wr(OFF_STACK_HEAD, 32'h012345);
    wr(OFF_STACK_HEAD, 32'h00ABCD);
    wr(OFF_STACK_HEAD, 32'h001111);
    wr(OFF_ACC_SHADOW, 32'hA5);
    wr(OFF_FLAGS_SHADOW, 32'h15);
    wr(OFF_BANK_SHADOW, 32'h9);
    wr(OFF_ACC, 32'h11);
    wr(OFF_FLAGS, 32'h04);
    wr(OFF_BANK, 32'h3);
    wr(OFF_PC_LATCH_HIGH, 32'h5A);
    wr(OFF_PC_LATCH_UPPER, 32'h13);
    rchk(OFF_STACK_LEVEL, 32'h3, "level pushed");
    // literal exit with the top literal value
    ret_chk(16'h0CFF, 21'h001111);
    rchk(OFF_ACC, 32'hFF, "acc literal");
    rchk(OFF_FLAGS, 32'h04, "flags after literal");
    rchk(OFF_STACK_LEVEL, 32'h2, "level after pop");
    rchk(OFF_STACK_HEAD, 32'h00ABCD, "new head");
    // subroutine exit without restore
    ret_chk(16'h0012, 21'h00ABCD);
    rchk(OFF_ACC, 32'hFF, "acc kept");
    rchk(OFF_FLAGS, 32'h04, "flags kept");
    rchk(OFF_IRQ_EN, 32'h0, "enables kept");
    // interrupt exit with restore, high level selected
    ret_chk(16'h0011, 21'h012345);
    rchk(OFF_ACC, 32'hA5, "acc restored");
    rchk(OFF_FLAGS, 32'h15, "flags restored");
    rchk(OFF_BANK, 32'h9, "bank restored");
    rchk(OFF_IRQ_EN, 32'h1, "high enable set");
    rchk(OFF_STACK_LEVEL, 32'h0, "level empty");
    // interrupt exit without restore, low level selected
    wr(OFF_CTRL, 32'h0);
    wr(OFF_STACK_HEAD, 32'h000200);
    wr(OFF_ACC, 32'h22);
    wr(OFF_FLAGS, 32'h00);
    ret_chk(16'h0010, 21'h000200);
    rchk(OFF_IRQ_EN, 32'h3, "low enable set");
    rchk(OFF_ACC, 32'h22, "acc untouched");
    rchk(OFF_FLAGS, 32'h00, "only enables change");
    // subroutine exit with restore
    wr(OFF_STACK_HEAD, 32'h000300);
    wr(OFF_ACC, 32'h00);
    wr(OFF_BANK, 32'h2);
    ret_chk(16'h0013, 21'h000300);
    rchk(OFF_ACC, 32'hA5, "acc restored sub");
    rchk(OFF_FLAGS, 32'h15, "flags restored sub");
    rchk(OFF_BANK, 32'h9, "bank restored sub");
    rchk(OFF_IRQ_EN, 32'h3, "enables kept sub");
    rchk(OFF_PC_LATCH_HIGH, 32'h5A, "high latch");
    rchk(OFF_PC_LATCH_UPPER, 32'h13, "upper latch");
    // a neighbouring pattern must not decode as a return
    wr(OFF_STACK_HEAD, 32'h000400);
    exec(16'h0014, 4);
    rchk(OFF_PC, 32'h000300, "no pop on other code");
    rchk(OFF_STACK_LEVEL, 32'h1, "level kept");
    // rotate through carry, both destinations, zero and negative cases
    for (i = 0; i < 4; i++) begin
      wr(F20, {24'h0, rv[i]});
      wr(OFF_FLAGS, {24'h0, cin[i]});
      wr(OFF_ACC, 32'h77);
      exec({6'h0D, dsel[i], 1'b0, 8'h20}, 4);
      rchk(OFF_FLAGS, {24'h0, fl[i]}, "rotate flags");
      rchk(OFF_ACC, dsel[i] ? 32'h77 : {24'h0, res[i]}, "rot acc");
      rchk(F20, {24'h0, dsel[i] ? res[i] : rv[i]}, "rot file");
    end
    wrap_up();
  end
endmodule : tb_top
